// >>> rtl/srh_host.sv
// host controller driving an asynchronous byte-wide static ram
module srh_host
    import srh_pkg::*;
#(
    parameter int unsigned AW = ADDR_W,
    parameter int unsigned DW = DATA_W
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic req_valid,
    input wire logic req_write,
    input wire logic [AW-1:0] req_addr,
    input wire logic [DW-1:0] req_wdata,
    output logic req_ready,
    output logic rsp_valid,
    output logic [DW-1:0] rsp_rdata,
    output logic select_low_active_n,
    output logic select_high_active,
    output logic write_strobe_n,
    output logic output_enable_n,
    output logic [AW-1:0] address_lines,
    input wire logic [DW-1:0] data_lines_i,
    output logic [DW-1:0] data_lines_o,
    output logic data_lines_oe
);
    // larger of two cycle counts, used for both access kinds
    function automatic int unsigned srh_max(input int unsigned a, input int unsigned b);
        return (a > b) ? a : b;
    endfunction : srh_max
    // interval lengths in cycles, cut to the counter width
    localparam logic [CNT_W-1:0] READ_LEN = CNT_W'(srh_max(READ_CYC, ACCESS_CYC));
    localparam logic [CNT_W-1:0] WRITE_LEN = CNT_W'(srh_max(WRITE_CYC, STROBE_CYC));
    localparam logic [CNT_W-1:0] FLOAT_LEN = CNT_W'(FLOAT_CYC);

    srh_state_type state_r;  // sequencer state
    srh_state_type state_nxt;
    logic sel_n_r, sel_n_nxt;  // low-active select
    logic sel_h_r, sel_h_nxt;  // high-active select
    logic we_n_r, we_n_nxt;  // write strobe
    logic oe_n_r, oe_n_nxt;  // output enable
    logic [AW-1:0] addr_r, addr_nxt;  // address pins
    logic [DW-1:0] wdat_r, wdat_nxt;  // data driven on write
    logic doe_r, doe_nxt;  // host drive enable
    logic rdy_r, rdy_nxt;  // ready for a request
    logic rv_r, rv_nxt;  // read answer pulse
    logic [DW-1:0] rdat_r, rdat_nxt;  // captured byte
    logic tload;  // start a timed interval
    logic [CNT_W-1:0] tcount;
    logic tdone;  // interval finished

    srh_timer #(.W(CNT_W)) u_timer (
        .clk(clk),
        .sys_rst(sys_rst),
        .load(tload),
        .count(tcount),
        .done(tdone)
    );

    // sequencer: every interval is a whole count of cycles
    always_comb begin
        state_nxt = state_r;
        sel_n_nxt = sel_n_r;
        sel_h_nxt = sel_h_r;
        we_n_nxt = we_n_r;
        oe_n_nxt = oe_n_r;
        addr_nxt = addr_r;
        wdat_nxt = wdat_r;
        doe_nxt = doe_r;
        rdy_nxt = rdy_r;
        rv_nxt = 1'b0;
        rdat_nxt = rdat_r;
        tload = 1'b0;
        tcount = READ_LEN;
        unique case (state_r)
            SRH_IDLE: begin
                // idle keeps the memory deselected and so powered down
                if (req_valid && rdy_r) begin
                    rdy_nxt = 1'b0;
                    addr_nxt = req_addr;
                    sel_n_nxt = 1'b0;
                    sel_h_nxt = 1'b1;
                    tload = 1'b1;
                    if (req_write) begin
                        // output enable stays high so memory never drives
                        wdat_nxt = req_wdata;
                        we_n_nxt = 1'b0;
                        doe_nxt = 1'b1;
                        tcount = WRITE_LEN;
                        state_nxt = SRH_WRITE;
                    end else begin
                        oe_n_nxt = 1'b0;
                        tcount = READ_LEN;
                        state_nxt = SRH_READ;
                    end
                end
            end
            SRH_READ: begin
                if (tdone) begin
                    // sample at the end of the full cycle, data valid by then
                    rdat_nxt = data_lines_i;
                    rv_nxt = 1'b1;
                    oe_n_nxt = 1'b1;
                    sel_n_nxt = 1'b1;
                    sel_h_nxt = 1'b0;
                    tload = 1'b1;
                    tcount = FLOAT_LEN;
                    state_nxt = SRH_FLOAT;
                end
            end
            SRH_WRITE: begin
                if (tdone) begin
                    // strobe rising ends the write, data still held
                    we_n_nxt = 1'b1;
                    state_nxt = SRH_HOLD;
                end
            end
            SRH_HOLD: begin
                // one cycle of data and address hold after write end
                doe_nxt = 1'b0;
                sel_n_nxt = 1'b1;
                sel_h_nxt = 1'b0;
                tload = 1'b1;
                tcount = FLOAT_LEN;
                state_nxt = SRH_FLOAT;
            end
            SRH_FLOAT: begin
                // wait for memory lines to float before next access
                if (tdone) begin
                    rdy_nxt = 1'b1;
                    state_nxt = SRH_IDLE;
                end
            end
            default: begin
                state_nxt = SRH_IDLE;
            end
        endcase
    end

    // register all pins so outputs come straight from flip-flops
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            state_r <= SRH_IDLE;
            sel_n_r <= 1'b1;
            sel_h_r <= 1'b0;
            we_n_r <= 1'b1;
            oe_n_r <= 1'b1;
            addr_r <= ADDR_RST;
            wdat_r <= DATA_RST;
            doe_r <= 1'b0;
            rdy_r <= 1'b1;
            rv_r <= 1'b0;
            rdat_r <= DATA_RST;
        end else begin
            state_r <= state_nxt;
            sel_n_r <= sel_n_nxt;
            sel_h_r <= sel_h_nxt;
            we_n_r <= we_n_nxt;
            oe_n_r <= oe_n_nxt;
            addr_r <= addr_nxt;
            wdat_r <= wdat_nxt;
            doe_r <= doe_nxt;
            rdy_r <= rdy_nxt;
            rv_r <= rv_nxt;
            rdat_r <= rdat_nxt;
        end
    end

    assign select_low_active_n = sel_n_r;
    assign select_high_active = sel_h_r;
    assign write_strobe_n = we_n_r;
    assign output_enable_n = oe_n_r;
    assign address_lines = addr_r;
    assign data_lines_o = wdat_r;
    assign data_lines_oe = doe_r;
    assign req_ready = rdy_r;
    assign rsp_valid = rv_r;
    assign rsp_rdata = rdat_r;

    // checks on the pin sequence
    sequence s_wr_start;
        $fell(we_n_r) && !sel_n_r && sel_h_r;
    endsequence
    sequence s_wr_hold;
        !we_n_r [*4];
    endsequence

    a_no_contention: assert property (@(posedge clk) disable iff (sys_rst)
        doe_r |-> oe_n_r)
        else $error("host drives while memory output enabled");
    a_strobe_width: assert property (@(posedge clk) disable iff (sys_rst)
        s_wr_start |-> s_wr_hold)
        else $error("write strobe too short");
    a_select_before_end: assert property (@(posedge clk) disable iff (sys_rst)
        $rose(we_n_r) |-> !$past(sel_n_r, 3) && !sel_n_r)
        else $error("select not held before write end");
    a_data_hold: assert property (@(posedge clk) disable iff (sys_rst)
        $rose(we_n_r) |-> doe_r && $stable(wdat_r) && $stable(addr_r))
        else $error("data or address changed at write end");
    a_read_length: assert property (@(posedge clk) disable iff (sys_rst)
        $fell(oe_n_r) |-> !oe_n_r [*4])
        else $error("read cycle too short");
    a_read_answer: assert property (@(posedge clk) disable iff (sys_rst)
        $fell(oe_n_r) |-> ##4 rv_r)
        else $error("read answer not on time");
    a_float_gap: assert property (@(posedge clk) disable iff (sys_rst)
        $rose(sel_n_r) |-> !rdy_r [*2])
        else $error("next access before lines float");
    a_write_overlap: assert property (@(posedge clk) disable iff (sys_rst)
        !we_n_r |-> !sel_n_r && sel_h_r && oe_n_r)
        else $error("strobe outside selected window");
endmodule : srh_host

// >>> rtl/srh_pkg.sv
// package of constants and types for the static ram host controller
// Notes on behaviour
// - select or strobe release ends write
// - strobe pulse covers float delay plus setup
// - host never drives while memory still drives
// - read cycle no shorter than grade cycle
// - select held before write end minimum
package srh_pkg;
    localparam int unsigned CLK_PERIOD_NS = 4;             // 250 mhz clock
    // timings of the fastest grade, in ns
    localparam int unsigned READ_CYCLE_MIN_NS = 15;
    localparam int unsigned ADDRESS_ACCESS_MAX_NS = 15;
    localparam int unsigned DRIVE_ENABLE_ACCESS_MAX_NS = 8;
    localparam int unsigned SELECT_TO_WRITE_END_MIN_NS = 12;
    localparam int unsigned STROBE_TO_FLOAT_MAX_NS = 7;
    localparam int unsigned DATA_SETUP_MIN_NS = 8;
    localparam int unsigned DESELECT_TO_FLOAT_MAX_NS = 7;
    localparam int unsigned POWERDOWN_DELAY_MAX_NS = 15;
    // least times round up to whole cycles
    function automatic int unsigned srh_cyc_up(input int unsigned ns);
        int unsigned c;
        c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
        return (c < 1) ? 1 : c;
    endfunction : srh_cyc_up
    localparam int unsigned READ_CYC = srh_cyc_up(READ_CYCLE_MIN_NS);
    localparam int unsigned ACCESS_CYC = srh_cyc_up(ADDRESS_ACCESS_MAX_NS);
    localparam int unsigned WRITE_CYC = srh_cyc_up(SELECT_TO_WRITE_END_MIN_NS);
    localparam int unsigned STROBE_CYC =
        srh_cyc_up(STROBE_TO_FLOAT_MAX_NS + DATA_SETUP_MIN_NS);
    localparam int unsigned FLOAT_CYC = srh_cyc_up(DESELECT_TO_FLOAT_MAX_NS);
    localparam int unsigned ADDR_W = 13;
    localparam int unsigned DATA_W = 8;
    localparam int unsigned CNT_W = 4;
    localparam logic [ADDR_W-1:0] ADDR_RST = 13'h0000;
    localparam logic [DATA_W-1:0] DATA_RST = 8'h00;
    typedef enum logic [4:0] {
        SRH_IDLE  = 5'b00001,
        SRH_READ  = 5'b00010,
        SRH_WRITE = 5'b00100,
        SRH_HOLD  = 5'b01000,
        SRH_FLOAT = 5'b10000
    } srh_state_type;
endpackage : srh_pkg

// >>> rtl/srh_timer.sv
// down counter that marks the end of a timed interval
module srh_timer
    import srh_pkg::*;
#(
    parameter int unsigned W = CNT_W
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic load,
    input wire logic [W-1:0] count,
    output logic done
);
    logic [W-1:0] cnt_r;  // cycles still to wait
    logic [W-1:0] cnt_nxt;
    // load takes priority so back to back intervals never merge
    always_comb begin
        cnt_nxt = cnt_r;
        if (load) begin
            cnt_nxt = count;
        end else if (cnt_r != '0) begin
            cnt_nxt = cnt_r - 1'b1;
        end
    end
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            cnt_r <= '0;
        end else begin
            cnt_r <= cnt_nxt;
        end
    end
    assign done = (cnt_r == {{(W-1){1'b0}}, 1'b1});
endmodule : srh_timer

// >>> verification/srh_mem_model.sv
// behavioural static ram standing on the far side of the host
module srh_mem_model #(
    parameter int ACC_NS = 15
) (
    input wire logic sel_n,
    input wire logic sel,
    input wire logic we_n,
    input wire logic oe_n,
    input wire logic [12:0] addr,
    input wire logic [7:0] bus,
    output logic [7:0] drv,
    output logic drv_en
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [7:0] mem [8192]; // byte array, 13-bit address
    logic wr_on = 1'b0; // a write window is open
    wire active = !sel_n && sel; // deselect powers down, strobes ignored
    wire wr = active && !we_n; // write window is the overlap
    wire rd = active && !oe_n && we_n;
    // byte captured on whichever edge closes the window
    always @(wr) begin
        if (wr) begin
            wr_on = 1'b1;
        end else if (wr_on) begin
            mem[addr] = bus;
            wr_on = 1'b0;
        end
    end
    // floats at once but data turns valid late, so a host that samples too early reads junk
    // released lines show the inverse of the last byte, so a stale sample never matches
    always @(rd or addr) begin
        if (rd) begin
            drv = ~mem[addr];
            drv <= #(ACC_NS) mem[addr];
        end else if (drv_en) begin
            drv = ~drv;
        end
        drv_en = rd;
    end
    initial drv = 8'h5a;
endmodule : srh_mem_model

// >>> verification/srh_host_tb_top.sv
// testbench for the static ram host controller
module srh_host_tb_top
    import srh_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic req_valid = 1'b0;
    logic req_write = 1'b0;
    logic [12:0] req_addr = 13'h0000;
    logic [7:0] req_wdata = 8'h00;
    logic req_ready, rsp_valid, sln, sh, we_n, oe_n, hoe, moe;
    logic [7:0] rsp_rdata, hdo, mdo, bus;
    logic [12:0] addr;
    int bad_count = 0;
    int comparisons = 0;
    // the model already inverts its lines when it lets go, never a stale match
    assign bus = hoe ? hdo : mdo;
    srh_host dut_u (.clk(clk), .sys_rst(sys_rst), .req_valid(req_valid),
        .req_write(req_write), .req_addr(req_addr), .req_wdata(req_wdata),
        .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata),
        .select_low_active_n(sln), .select_high_active(sh), .write_strobe_n(we_n),
        .output_enable_n(oe_n), .address_lines(addr), .data_lines_i(bus),
        .data_lines_o(hdo), .data_lines_oe(hoe));
    srh_mem_model #(.ACC_NS(15)) mem_u (.sel_n(sln), .sel(sh), .we_n(we_n),
        .oe_n(oe_n), .addr(addr), .bus(bus), .drv(mdo), .drv_en(moe));
    initial begin
        forever #2 clk = ~clk;
    end
    task automatic check(input logic ok, input string msg);
        comparisons++;
        if (ok !== 1'b1) begin
            bad_count++;
            $display("wrong value at %0t: %s", $time, msg);
        end
    endtask : check
    task automatic final_report();
        if (bad_count == 0 && comparisons > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : final_report
    // one request, held until taken; counts strobe or enable cycles after the take
    task automatic op(input logic w, input logic [12:0] a, input logic [7:0] d,
                      output int lo, output logic [7:0] rd);
        int n;
        lo = 0;
        n = 0;
        @(posedge clk);
        req_valid <= 1'b1;
        req_write <= w;
        req_addr <= a;
        req_wdata <= d;
        do begin
            @(negedge clk);
            n++;
        end while (req_ready !== 1'b1 && n < 50);
        @(posedge clk);
        req_valid <= 1'b0;
        for (int i = 0; i < 6; i++) begin
            @(negedge clk);
            if ((w ? we_n : oe_n) === 1'b0) lo++;
            check(rsp_valid === ((i == 4) && !w), "read answer timing");
            check(req_ready === 1'b0, "ready while busy");
            if (i < 4) check(sln === 1'b0 && sh === 1'b1, "select not held");
            if (w) check(oe_n === 1'b1, "output enable during write");
            if (i > 0 && i < 5) check(addr === a, "address not held");
            if (i > 0 && i < 5 && w) check(hoe === 1'b1 && hdo === d, "write data");
        end
        rd = rsp_rdata;
    endtask : op
    // write; strobe must last ceil((7+8)/4) = 4 cycles
    task automatic wr(input logic [12:0] a, input logic [7:0] d);
        int lo;
        logic [7:0] rd;
        op(1'b1, a, d, lo, rd);
        check(lo == 4, "strobe length");
    endtask : wr
    // read; enable must last ceil(15/4) = 4 cycles
    task automatic rd_chk(input logic [12:0] a, input logic [7:0] e);
        int lo;
        logic [7:0] rd;
        op(1'b0, a, 8'h00, lo, rd);
        check(lo == 4, "read enable length");
        check(rd === e, "read data");
    endtask : rd_chk
    // both ends of the address space, back to back
    task automatic t_bounds();
        wr(13'h0000, 8'ha5);
        wr(13'h1fff, 8'h5a);
        rd_chk(13'h1fff, 8'h5a);
        rd_chk(13'h0000, 8'ha5);
    endtask : t_bounds
    // overwrite keeps only the newest byte
    task automatic t_overwrite();
        wr(13'h0a55, 8'h3c);
        wr(13'h0a55, 8'hc3);
        rd_chk(13'h0a55, 8'hc3);
    endtask : t_overwrite
    // reset in mid write: pins return to deselect, old bytes survive
    task automatic t_mid_reset();
        @(posedge clk);
        req_valid <= 1'b1;
        req_write <= 1'b1;
        req_addr <= 13'h1234;
        @(negedge clk);
        repeat (2) @(posedge clk);
        req_valid <= 1'b0;
        sys_rst <= 1'b1;
        @(negedge clk);
        check(sln === 1'b1 && sh === 1'b0 && we_n === 1'b1, "pins in reset");
        check(hoe === 1'b0 && req_ready === 1'b1, "bus in reset");
        @(posedge clk);
        sys_rst <= 1'b0;
        // the cut write may land anywhere, so only untouched bytes are judged
        rd_chk(13'h1fff, 8'h5a);
        rd_chk(13'h0a55, 8'hc3);
    endtask : t_mid_reset
    // host must never drive while memory drives
    always @(negedge clk) begin
        if (hoe === 1'b1) check(moe !== 1'b1, "bus contention");
    end
    initial begin
        repeat (20000) @(posedge clk);
        bad_count++;
        final_report();
    end
    initial begin
        repeat (20) @(posedge clk);
        sys_rst <= 1'b0;
        t_bounds();
        t_overwrite();
        t_mid_reset();
        final_report();
    end
endmodule : srh_host_tb_top
